/* File: src/tcc_pkg.sv */
// constants shared by the timer capture/compare channel block
package tcc_pkg;
	// structure widths
	localparam int NCH = 8;  // number of timer channels
	localparam int CW  = 16; // timer counter and channel value width
	localparam int AW  = 5;  // register address width
	localparam int DW  = 16; // register data width
	localparam int PW  = 8;  // precision prescale value width

	// register offsets (word index on the plain register port)
	localparam logic [AW-1:0] OFS_CTRL     = 5'h00; // timer_system_control_one
	localparam logic [AW-1:0] OFS_PSC      = 5'h01; // precision_prescale_value
	localparam logic [AW-1:0] OFS_DIR      = 5'h02; // channel_direction_select_reg
	localparam logic [AW-1:0] OFS_FORCE    = 5'h03; // force_compare_reg_bit, write only
	localparam logic [AW-1:0] OFS_MODE     = 5'h04; // compare_output_mode per channel
	localparam logic [AW-1:0] OFS_LEVEL    = 5'h05; // compare_output_level per channel
	localparam logic [AW-1:0] OFS_DISC     = 5'h06; // compare_pin_disconnect per channel
	localparam logic [AW-1:0] OFS_IRQ_EN   = 5'h07; // channel_irq_enable (interrupt mask)
	localparam logic [AW-1:0] OFS_FLAG     = 5'h08; // channel_event_flag, write one to clear while the timer is enabled
	localparam logic [AW-1:0] OFS_PORT     = 5'h09; // general-purpose port latch
	localparam logic [AW-1:0] OFS_CNT      = 5'h0A; // timer counter, read only
	localparam logic [AW-1:0] OFS_EDGE_R   = 5'h0B; // capture on rising edge enables
	localparam logic [AW-1:0] OFS_EDGE_F   = 5'h0C; // capture on falling edge enables
	localparam logic [AW-1:0] OFS_VAL_BASE = 5'h10; // channel values at base + channel

	// control register field positions
	localparam int CTRL_TEN_BIT  = 0; // timer_enable
	localparam int CTRL_PRECISION_PRESCALE_ENABLE_BIT = 1; // precision_prescale_enable

	// reset values
	localparam logic [NCH-1:0] RST_CH    = 8'h00;
	localparam logic [PW-1:0]  RST_PSC   = 8'h00;
	localparam logic [CW-1:0]  RST_CNT   = 16'h0000;
	localparam logic [DW-1:0]  RST_RDATA = 16'h0000;

	// compare pin action, coded as {compare_output_mode, compare_output_level}
	localparam logic [1:0] ACT_NONE   = 2'h0;
	localparam logic [1:0] ACT_TOGGLE = 2'h1;
	localparam logic [1:0] ACT_CLEAR  = 2'h2;
	localparam logic [1:0] ACT_SET    = 2'h3;
endpackage : tcc_pkg

/* File: src/timer_capture_compare_channels.sv */
// timer counter with prescaler and eight input capture / output compare channels
`timescale 1ns/1ps
module timer_capture_compare_channels (
	input  wire logic                       clk_i,       // bus clock
	input  wire logic                       rstn_i,      // async reset, active low
	input  wire logic                       ce_i,        // clock enable, freezes all state
	input  wire logic [tcc_pkg::AW-1:0]     addr_i,      // register index
	input  wire logic [tcc_pkg::DW-1:0]     wdata_i,     // write data
	input  wire logic                       wr_i,        // write strobe
	input  wire logic                       rd_i,        // read strobe
	output logic      [tcc_pkg::DW-1:0]     rdata_o,     // read data, cycle after rd_i
	input  wire logic [tcc_pkg::NCH-1:0]    cap_pin_i,   // capture event pins
	output logic      [tcc_pkg::NCH-1:0]    compare_output_signal_o, // channel pins
	output logic                            irq_o        // level interrupt
);
	import tcc_pkg::*;

	// software visible control state
	logic            timer_enable_ff;               // counter runs while set
	logic            precision_prescale_enable_ff;  // use programmable prescale
	logic [PW-1:0]   precision_prescale_value_ff;   // ratio minus one
	logic [NCH-1:0]  channel_direction_select_ff;   // 1 = compare, 0 = capture
	logic [NCH-1:0]  compare_output_mode_ff;        // action select high bit
	logic [NCH-1:0]  compare_output_level_ff;       // action select low bit
	logic [NCH-1:0]  compare_pin_disconnect_ff;     // pin not driven by compare logic
	logic [NCH-1:0]  channel_irq_enable_ff;         // interrupt mask
	logic [NCH-1:0]  channel_event_flag_ff;         // sticky event flags
	logic [NCH-1:0]  port_latch_ff;                 // general-purpose output data
	logic [NCH-1:0]  edge_rise_ff;                  // capture on rising edge
	logic [NCH-1:0]  edge_fall_ff;                  // capture on falling edge

	// timer core state
	logic [PW-1:0]   psc_cnt_ff;                    // prescaler phase
	logic [CW-1:0]   cnt_ff;                        // timer counter
	logic [CW-1:0]   nxt_cnt;                       // counter plus one
	logic [PW-1:0]   psc_lim;                       // prescaler terminal phase
	logic            tick;                          // counter advances this cycle

	// per-channel wires gathered from the generate loop
	logic [CW-1:0]   val_w [NCH];                   // channel capture/compare values
	logic [NCH-1:0]  oc_w;                          // internal compare output registers
	logic [NCH-1:0]  cap_ev;                        // capture event this cycle
	logic [NCH-1:0]  match_ev;                      // compare match this cycle
	logic [NCH-1:0]  flag_clr;                      // flags cleared by software
	logic [NCH-1:0]  nxt_flag;                      // next flag state
	logic [NCH-1:0]  pin_sel;                       // compare logic owns the pin

	// register port decode
	logic            wr_ctrl;
	logic            wr_force;
	logic            wr_flag;
	logic [DW-1:0]   nxt_rdata;

	// selected action applied to the current output value
	function automatic logic apply_act(input logic [1:0] act, input logic cur);
		logic r;
		r = cur;
		unique case (act)
			ACT_NONE:   r = cur;
			ACT_TOGGLE: r = ~cur;
			ACT_CLEAR:  r = 1'b0;
			ACT_SET:    r = 1'b1;
		endcase
		return r;
	endfunction : apply_act

	assign wr_ctrl  = wr_i && (addr_i == OFS_CTRL);
	assign wr_force = wr_i && (addr_i == OFS_FORCE);
	assign wr_flag  = wr_i && (addr_i == OFS_FLAG);

	// control registers; force register is a strobe and keeps no state
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			timer_enable_ff              <= 1'b0;
			precision_prescale_enable_ff <= 1'b0;
			precision_prescale_value_ff  <= RST_PSC;
			channel_direction_select_ff  <= RST_CH;
			compare_output_mode_ff       <= RST_CH;
			compare_output_level_ff      <= RST_CH;
			compare_pin_disconnect_ff    <= RST_CH;
			channel_irq_enable_ff        <= RST_CH;
			port_latch_ff                <= RST_CH;
			edge_rise_ff                 <= RST_CH;
			edge_fall_ff                 <= RST_CH;
		end else if (ce_i && wr_i) begin
			unique case (addr_i)
				OFS_CTRL: begin
					timer_enable_ff              <= wdata_i[CTRL_TEN_BIT];
					precision_prescale_enable_ff <= wdata_i[CTRL_PRECISION_PRESCALE_ENABLE_BIT];
				end
				OFS_PSC:    precision_prescale_value_ff <= wdata_i[PW-1:0];
				OFS_DIR:    channel_direction_select_ff <= wdata_i[NCH-1:0];
				OFS_MODE:   compare_output_mode_ff      <= wdata_i[NCH-1:0];
				OFS_LEVEL:  compare_output_level_ff     <= wdata_i[NCH-1:0];
				OFS_DISC:   compare_pin_disconnect_ff   <= wdata_i[NCH-1:0];
				OFS_IRQ_EN: channel_irq_enable_ff       <= wdata_i[NCH-1:0];
				OFS_PORT:   port_latch_ff               <= wdata_i[NCH-1:0];
				OFS_EDGE_R: edge_rise_ff                <= wdata_i[NCH-1:0];
				OFS_EDGE_F: edge_fall_ff                <= wdata_i[NCH-1:0];
				default: ; // other offsets have their own processes or are unmapped
			endcase
		end
	end

	// prescaler: ratio is value+1 when enabled, otherwise every cycle
	assign psc_lim = precision_prescale_enable_ff ? precision_prescale_value_ff : RST_PSC;
	// >= so that lowering the ratio mid-count can never strand the phase
	assign tick    = timer_enable_ff && (psc_cnt_ff >= psc_lim);
	assign nxt_cnt = CW'(cnt_ff + 1'b1);

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			psc_cnt_ff <= RST_PSC;
		end else if (ce_i && timer_enable_ff) begin
			psc_cnt_ff <= tick ? RST_PSC : PW'(psc_cnt_ff + 1'b1);
		end
	end

	// timer counter holds while disabled, wraps freely
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt_ff <= RST_CNT;
		end else if (ce_i && tick) begin
			cnt_ff <= nxt_cnt;
		end
	end

	// per-channel capture, compare and output register
	genvar i;
	generate
		for (i = 0; i < NCH; i++) begin : g_ch
			logic [CW-1:0] val_ff;   // capture/compare value
			logic          oc_ff;    // internal compare output register
			logic          smp_ff;   // pin sample
			logic          prev_ff;  // previous pin sample, for edges
			logic          dir;      // channel in compare mode
			logic          fbit;     // force strobe for this channel
			logic [1:0]    act;      // pin action on match or force

			assign dir = channel_direction_select_ff[i];
			assign act = {compare_output_mode_ff[i], compare_output_level_ff[i]};
			assign fbit = wr_force && wdata_i[i];
			// pin is sampled once; a pulse of one clock or longer is never missed
			assign cap_ev[i] = !dir && ((edge_rise_ff[i] && smp_ff && !prev_ff) ||
				(edge_fall_ff[i] && !smp_ff && prev_ff));
			// match when the counter steps onto the channel value
			assign match_ev[i] = dir && tick && (nxt_cnt == val_ff);
			assign val_w[i] = val_ff;
			assign oc_w[i]  = oc_ff;

			// edge detector on the synchronous pin input
			always_ff @(posedge clk_i or negedge rstn_i) begin
				if (!rstn_i) begin
					smp_ff  <= 1'b0;
					prev_ff <= 1'b0;
				end else if (ce_i) begin
					smp_ff  <= cap_pin_i[i];
					prev_ff <= smp_ff;
				end
			end

			// value: capture beats a software write in the same cycle
			always_ff @(posedge clk_i or negedge rstn_i) begin
				if (!rstn_i) begin
					val_ff <= RST_CNT;
				end else if (ce_i) begin
					if (cap_ev[i]) begin
						val_ff <= cnt_ff;
					end else if (wr_i && (addr_i == AW'(OFS_VAL_BASE + i))) begin
						val_ff <= wdata_i[CW-1:0];
					end
				end
			end

			// output register: forced preset, forced action or match action
			always_ff @(posedge clk_i or negedge rstn_i) begin
				if (!rstn_i) begin
					oc_ff <= 1'b0;
				end else if (ce_i && dir) begin
					if (fbit && compare_pin_disconnect_ff[i]) begin
						// preset before the pin is handed over; only set or clear
						if (timer_enable_ff && compare_output_mode_ff[i]) begin
							oc_ff <= compare_output_level_ff[i];
						end
					end else if (fbit) begin
						oc_ff <= apply_act(act, oc_ff);
					end else if (match_ev[i] && !compare_pin_disconnect_ff[i]) begin
						oc_ff <= apply_act(act, oc_ff);
					end
				end
			end
		end
	endgenerate

	// flags: hardware set wins over software clear in the same cycle
	assign flag_clr = (wr_flag && timer_enable_ff) ? wdata_i[NCH-1:0] : RST_CH;
	assign nxt_flag = (channel_event_flag_ff & ~flag_clr) | cap_ev | match_ev;

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			channel_event_flag_ff <= RST_CH;
		end else if (ce_i) begin
			channel_event_flag_ff <= nxt_flag;
		end
	end

	// interrupt level from masked flags, registered
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			irq_o <= 1'b0;
		end else if (ce_i) begin
			irq_o <= |(channel_event_flag_ff & channel_irq_enable_ff);
		end
	end

	// pin mux: compare logic on connected compare channels, else the port latch
	assign pin_sel = channel_direction_select_ff & ~compare_pin_disconnect_ff;

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			compare_output_signal_o <= RST_CH;
		end else if (ce_i) begin
			compare_output_signal_o <= (pin_sel & oc_w) | (~pin_sel & port_latch_ff);
		end
	end

	// read mux; unmapped and write-only offsets read zero
	always_comb begin
		nxt_rdata = RST_RDATA;
		unique case (addr_i)
			OFS_CTRL: begin
				nxt_rdata[CTRL_TEN_BIT]  = timer_enable_ff;
				nxt_rdata[CTRL_PRECISION_PRESCALE_ENABLE_BIT] = precision_prescale_enable_ff;
			end
			OFS_PSC:    nxt_rdata[PW-1:0]  = precision_prescale_value_ff;
			OFS_DIR:    nxt_rdata[NCH-1:0] = channel_direction_select_ff;
			OFS_MODE:   nxt_rdata[NCH-1:0] = compare_output_mode_ff;
			OFS_LEVEL:  nxt_rdata[NCH-1:0] = compare_output_level_ff;
			OFS_DISC:   nxt_rdata[NCH-1:0] = compare_pin_disconnect_ff;
			OFS_IRQ_EN: nxt_rdata[NCH-1:0] = channel_irq_enable_ff;
			OFS_FLAG:   nxt_rdata[NCH-1:0] = channel_event_flag_ff;
			OFS_PORT:   nxt_rdata[NCH-1:0] = port_latch_ff;
			OFS_CNT:    nxt_rdata[CW-1:0]  = cnt_ff;
			OFS_EDGE_R: nxt_rdata[NCH-1:0] = edge_rise_ff;
			OFS_EDGE_F: nxt_rdata[NCH-1:0] = edge_fall_ff;
			default: begin
				// channel values sit in a window of their own
				if (addr_i >= OFS_VAL_BASE && addr_i < AW'(OFS_VAL_BASE + NCH)) begin
					nxt_rdata[CW-1:0] = val_w[3'(addr_i - OFS_VAL_BASE)];
				end
			end
		endcase
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rdata_o <= RST_RDATA;
		end else if (ce_i) begin
			rdata_o <= rd_i ? nxt_rdata : RST_RDATA;
		end
	end

	// checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);

	// prescaler phase advances by one between ticks
	property p_psc_step;
		ce_i && timer_enable_ff && !tick |=> psc_cnt_ff == $past(psc_cnt_ff) + 1'b1;
	endproperty
	a_psc_step: assert property (p_psc_step) else $error("prescaler phase did not step");

	// every tick restarts the phase, so with the step check the ratio is value plus one
	property p_psc_ratio;
		ce_i && tick |=> psc_cnt_ff == RST_PSC;
	endproperty
	a_psc_ratio: assert property (p_psc_ratio) else $error("phase not restarted after tick");

	// counter steps on a tick and holds otherwise
	property p_cnt_step;
		ce_i |=> cnt_ff == ($past(tick) ? $past(nxt_cnt) : $past(cnt_ff));
	endproperty
	a_cnt_step: assert property (p_cnt_step) else $error("counter step wrong");

	// flag clear by software takes effect on every written channel unless an event arrives
	property p_flag_clear;
		ce_i && wr_flag && timer_enable_ff
			|=> (channel_event_flag_ff & $past(flag_clr) & ~$past(cap_ev) & ~$past(match_ev)) == RST_CH;
	endproperty
	a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

	// clear ignored while the timer is disabled
	property p_flag_hold;
		ce_i && !timer_enable_ff
			|=> (channel_event_flag_ff & $past(channel_event_flag_ff)) == $past(channel_event_flag_ff);
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("flag lost while disabled");

	// a capture latches the counter and raises the flag, then the interrupt if enabled;
	// channel 5 is watched since it is a capture channel with its interrupt on
	sequence s_cap0;
		ce_i && cap_ev[5] && channel_irq_enable_ff[5];
	endsequence
	sequence s_cap_done;
		val_w[5] == $past(cnt_ff) && channel_event_flag_ff[5] ##1 irq_o;
	endsequence
	property p_capture;
		s_cap0 ##1 (ce_i && channel_irq_enable_ff[5]) |-> s_cap_done;
	endproperty
	a_capture: assert property (p_capture) else $error("capture not taken");

	// a match sets the flag
	property p_match_flag;
		ce_i && match_ev[0] |=> channel_event_flag_ff[0];
	endproperty
	a_match_flag: assert property (p_match_flag) else $error("match flag missing");

	// action none leaves the output register untouched on a match
	property p_no_action;
		ce_i && match_ev[0] && !wr_force && !compare_output_mode_ff[0]
			&& !compare_output_level_ff[0] |=> $stable(oc_w[0]);
	endproperty
	a_no_action: assert property (p_no_action) else $error("action taken in none mode");

	// forced compare never touches the flag
	property p_force_noflag;
		ce_i && wr_force && !channel_event_flag_ff[0] && !cap_ev[0] && !match_ev[0]
			|=> !channel_event_flag_ff[0];
	endproperty
	a_force_noflag: assert property (p_force_noflag) else $error("force set flag");

	// forced preset while disconnected, watched on channel 3
	property p_preset;
		ce_i && wr_force && wdata_i[3] && timer_enable_ff && channel_direction_select_ff[3]
			&& compare_pin_disconnect_ff[3] && compare_output_mode_ff[3]
			|=> oc_w[3] == $past(compare_output_level_ff[3]);
	endproperty
	a_preset: assert property (p_preset) else $error("preset wrong");

	// disconnected or capture pins show the port latch
	property p_port_pin;
		ce_i && !pin_sel[0] |=> compare_output_signal_o[0] == $past(port_latch_ff[0]);
	endproperty
	a_port_pin: assert property (p_port_pin) else $error("port latch not on pin");

	// toggle mode inverts the output on a connected match, watched on channel 1
	property p_toggle;
		ce_i && match_ev[1] && !wr_force && !compare_pin_disconnect_ff[1]
			&& !compare_output_mode_ff[1] && compare_output_level_ff[1]
			|=> oc_w[1] != $past(oc_w[1]) ##1 (!ce_i || compare_output_signal_o[1] == $past(oc_w[1]));
	endproperty
	a_toggle: assert property (p_toggle) else $error("toggle missing");
endmodule : timer_capture_compare_channels

/* File: tb/tcc_pins_model.sv */
// stand-in for the external event sources that feed the capture pins
`timescale 1ns/1ps
module tcc_pins_model (
	input  wire logic                    clk_i, // bus clock
	output logic      [tcc_pkg::NCH-1:0] pin_o  // capture event pins, idle low
);
	import tcc_pkg::*;

	// pins rest low between events
	initial begin
		pin_o = '0;
	end

	// one event pulse, called right after a rising edge
	// held three clocks: only pulses shorter than one clock may slip past the edge sampler
	task automatic pulse(input int ch);
		pin_o[ch] <= 1'h1;
		repeat (3) @(posedge clk_i);
		pin_o[ch] <= 1'h0;
		@(posedge clk_i);
	endtask : pulse
endmodule : tcc_pins_model

/* File: tb/timer_capture_compare_channels_bench.sv */
// self-checking bench for the timer capture/compare channel block
`timescale 1ns/1ps
module timer_capture_compare_channels_bench;
	import tcc_pkg::*;
	typedef struct {logic [DW-1:0] exp; bit chk; string name;} note_t; // one expected read

	logic           clk_i       = 1'h0;  // 20 MHz bus clock
	logic           rstn_i      = 1'h0;  // reset, active low
	logic           ce_i        = 1'h1;  // clock enable, dropped for ten clocks in the freeze test
	logic [AW-1:0]  addr_i      = '0;    // register index
	logic [DW-1:0]  wdata_i     = '0;    // write data
	logic           wr_i        = 1'h0;  // write strobe
	logic           rd_i        = 1'h0;  // read strobe
	logic [DW-1:0]  rdata_o;             // read data
	logic [NCH-1:0] cap_pin_i;           // from the pin model
	logic [NCH-1:0] pin_o;               // compare pins
	logic           irq_o;               // interrupt level
	logic           rd_dly      = 1'h0;  // read answered in this cycle
	logic [DW-1:0]  last_rd     = '0;    // newest read data
	note_t          notes[$];            // reads still to be answered
	int             n_fail      = 0;     // mismatches
	int             check_count = 0;     // comparisons made
	logic [DW-1:0]  c0;                  // counter snapshot
	logic [PW-1:0]  pv;                  // prescale value under test
	int             r;                   // expected division ratio

	timer_capture_compare_channels i_dut (
		.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.cap_pin_i(cap_pin_i), .compare_output_signal_o(pin_o), .irq_o(irq_o)
	);
	tcc_pins_model i_pins (.clk_i(clk_i), .pin_o(cap_pin_i));

	always #25 clk_i = ~clk_i;

	// compare and count
	task automatic check(input string n, input logic [DW-1:0] e, input logic [DW-1:0] s);
		check_count++;
		if (s !== e) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask : check

	// verdict, reached from the main sequence and the watchdog
	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : finish_test

	// one write cycle, then an idle cycle so strobes never merge
	task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'h1;
		@(posedge clk_i);
		wr_i <= 1'h0;
		@(posedge clk_i);
	endtask : wr

	// one read cycle; the expectation is queued for the monitor
	task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] e, input bit c,
		input string n);
		notes.push_back(note_t'{e, c, n});
		addr_i <= a;
		rd_i   <= 1'h1;
		@(posedge clk_i);
		rd_i <= 1'h0;
		@(posedge clk_i);
	endtask : rd

	// pins and irq are registered: let them settle, look mid-cycle, realign
	task automatic look(input string n, input logic [DW-1:0] e);
		repeat (3) @(posedge clk_i);
		@(negedge clk_i);
		check(n, e, (n == "irq") ? {15'h0000, irq_o} : {8'h00, pin_o});
		@(posedge clk_i);
	endtask : look

	// wait until the counter steps; with ratio 256 it then stays put a long while
	task automatic sync_tick();
		int i;
		rd(OFS_CNT, '0, 1'b0, "cnt");
		c0 = last_rd;
		for (i = 0; i < 300; i++) begin
			rd(OFS_CNT, '0, 1'b0, "cnt");
			if (last_rd !== c0) break;
		end
		if (i == 300) begin
			n_fail++;
			finish_test();
		end
		c0 = last_rd;
	endtask : sync_tick

	// read data stand only in the cycle after the strobe
	always @(posedge clk_i) rd_dly <= rd_i;

	// monitor: match each answered read with the oldest note
	always @(negedge clk_i) begin
		note_t nt;
		if (rd_dly) begin
			last_rd = rdata_o;
			if (notes.size() == 0) check("queue", 16'h0001, 16'h0000);
			else begin
				nt = notes.pop_front();
				if (nt.chk) check(nt.name, nt.exp, rdata_o);
			end
		end
	end

	// watchdog: a hang counts as a mismatch
	initial begin
		repeat (60000) @(posedge clk_i);
		n_fail++;
		finish_test();
	end

	initial begin
		r = $urandom(32'h0000_9a3c);
		repeat (3) @(posedge clk_i);
		rstn_i <= 1'h1;
		@(posedge clk_i);
		// reset values, read back, unmapped and write-only places
		rd(OFS_CTRL, 16'h0000, 1'b1, "ctrl");
		rd(OFS_CNT, RST_CNT, 1'b1, "cnt reset");
		wr(5'h1F, 16'hFFFF);
		rd(5'h1F, 16'h0000, 1'b1, "unmapped");
		wr(OFS_DIR, 16'h00A5);
		rd(OFS_DIR, 16'h00A5, 1'b1, "dir");
		rd(OFS_FORCE, 16'h0000, 1'b1, "force");
		$display("test registers done");
		// counter rate: ratios 1, 256, two random, and prescaler off
		for (int k = 0; k < 5; k++) begin
			pv = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : PW'($urandom_range(40, 1));
			r = (k == 4) ? 1 : pv + 1;
			wr(OFS_PSC, {8'h00, pv});
			wr(OFS_CTRL, (k == 4) ? 16'h0001 : 16'h0003);
			rd(OFS_CNT, '0, 1'b0, "cnt");
			c0 = last_rd;
			repeat (3 * r - 2) @(posedge clk_i);
			rd(OFS_CNT, c0 + 16'h0003, 1'b1, "cnt step");
		end
		wr(OFS_CTRL, 16'h0000);
		rd(OFS_CNT, '0, 1'b0, "cnt");
		c0 = last_rd;
		repeat (20) @(posedge clk_i);
		rd(OFS_CNT, c0, 1'b1, "cnt held");
		// clock enable low freezes the running counter: two ticks land, ten do not
		wr(OFS_CTRL, 16'h0001);
		rd(OFS_CNT, '0, 1'b0, "cnt");
		c0 = last_rd;
		ce_i <= 1'h0;
		repeat (10) @(posedge clk_i);
		ce_i <= 1'h1;
		rd(OFS_CNT, c0 + 16'h0002, 1'b1, "cnt frozen");
		$display("test counter done");
		// capture: ch3 compare, ch4/5 rising, ch6 falling, ch7 no edge
		wr(OFS_PSC, 16'h00FF);
		wr(OFS_CTRL, 16'h0003);
		wr(OFS_DIR, 16'h000F);
		wr(OFS_EDGE_R, 16'h0038);
		wr(OFS_EDGE_F, 16'h0040);
		wr(OFS_IRQ_EN, 16'h0020);
		sync_tick();
		for (int ch = 3; ch < 8; ch++) i_pins.pulse(ch);
		for (int ch = 4; ch < 7; ch++) rd(AW'(OFS_VAL_BASE + ch), c0, 1'b1, "capture");
		rd(OFS_FLAG, 16'h0070, 1'b1, "flag capture");
		look("irq", 16'h0001);
		wr(OFS_IRQ_EN, 16'h0000);
		look("irq", 16'h0000);
		wr(OFS_IRQ_EN, 16'h0020);
		look("irq", 16'h0001);
		wr(OFS_CTRL, 16'h0000);
		wr(OFS_FLAG, 16'h0070);
		rd(OFS_FLAG, 16'h0070, 1'b1, "flag kept");
		wr(OFS_CTRL, 16'h0003);
		wr(OFS_FLAG, 16'h0070);
		rd(OFS_FLAG, 16'h0000, 1'b1, "flag cleared");
		look("irq", 16'h0000);
		$display("test capture done");
		// compare: ch0 none, ch1 toggle, ch2 set then clear, ch3 set
		wr(OFS_IRQ_EN, 16'h000F);
		wr(OFS_MODE, 16'h000C);
		wr(OFS_LEVEL, 16'h000E);
		wr(OFS_FORCE, 16'h000F);
		look("pins force", 16'h000E);
		rd(OFS_FLAG, 16'h0000, 1'b1, "flag force");
		wr(OFS_LEVEL, 16'h000A);
		wr(OFS_PORT, 16'h00FF);
		look("pins port", 16'h00FE);
		sync_tick();
		for (int ch = 0; ch < 4; ch++) wr(AW'(OFS_VAL_BASE + ch), c0 + 16'h0001);
		repeat (300) @(posedge clk_i);
		look("pins match", 16'h00F8);
		rd(OFS_FLAG, 16'h000F, 1'b1, "flag match");
		look("irq", 16'h0001);
		$display("test compare done");
		// disconnected pins follow the port latch; force only presets
		wr(OFS_PORT, 16'h0005);
		wr(OFS_DISC, 16'h000F);
		look("pins port", 16'h0005);
		wr(OFS_LEVEL, 16'h0006);
		wr(OFS_FORCE, 16'h000F);
		look("pins held", 16'h0005);
		wr(OFS_DISC, 16'h0000);
		look("pins preset", 16'h0004);
		$display("test preset done");
		finish_test();
	end
endmodule : timer_capture_compare_channels_bench
